// >>> hdl/char_fifo.sv
`timescale 1ns/10ps
module char_fifo
  import shadow_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Queue port
  char_fifo_if.store fif
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][CHAR_W-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic do_push;
  logic do_pop;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    do_push = fif.push && (q.count != CNT_W'(FIFO_DEPTH));
    do_pop = fif.pop && (q.count != '0);
    if (do_push) begin
      d.mem[q.wr_ptr] = fif.wdata;
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      d.count = q.count + 1'b1;
    end else if (do_pop && !do_push) begin
      d.count = q.count - 1'b1;
    end
    if (fif.flush) begin
      d.wr_ptr = '0;
      d.rd_ptr = '0;
      d.count = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  assign fif.rdata = q.mem[q.rd_ptr];
  assign fif.full = (q.count == CNT_W'(FIFO_DEPTH));
  assign fif.empty = (q.count == '0);
endmodule : char_fifo

// >>> hdl/char_fifo_if.sv
`timescale 1ns/10ps
interface char_fifo_if;
  import shadow_pkg::*;
  logic push;
  logic pop;
  logic flush;
  logic [CHAR_W-1:0] wdata;
  logic [CHAR_W-1:0] rdata;
  logic full;
  logic empty;
  modport store (input push, input pop, input flush, input wdata,
                 output rdata, output full, output empty);
  modport user (output push, output pop, output flush, output wdata,
                input rdata, input full, input empty);
endinterface : char_fifo_if

// >>> hdl/shadow_data_port.sv
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module shadow_data_port
  import shadow_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // Serial receive side
  input wire logic SER_RX_VALID,
  input wire logic [CHAR_W-1:0] SER_RX_CHAR,
  // Infrared receive side
  input wire logic IR_RX_VALID,
  input wire logic [CHAR_W-1:0] IR_RX_CHAR,
  // Transmit side
  output logic SER_TX_VALID,
  output logic IR_TX_VALID,
  output logic [CHAR_W-1:0] TX_CHAR,
  input wire logic TX_TAKE,
  // Status towards the core
  output logic DATA_READY,
  output logic TX_HOLD_EMPTY,
  output logic FIFO_ENABLE,
  // Interrupt
  output logic IRQ
);
  typedef struct packed {
    logic fifo_en;
    logic ir_mode;
    logic [CHAR_W-1:0] rx_hold;
    logic rx_hold_v;
    logic [CHAR_W-1:0] tx_hold;
    logic tx_hold_v;
    logic [CHAR_W-1:0] stage;
    logic stage_v;
    logic ser_v;
    logic ir_v;
    logic overrun;
    logic transmit_holding_empty_prev;
    logic ready_o;
    logic transmit_holding_empty_o;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } port_state_t;

  typedef enum logic [2:0] {
    sel_none = 3'b000,
    sel_data = 3'b001,
    sel_fifo = 3'b010,
    sel_line = 3'b011,
    sel_mode = 3'b100,
    sel_istat = 3'b101,
    sel_imask = 3'b110
  } reg_sel_t;

  port_state_t q;
  port_state_t d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic rx_ev;
  logic [CHAR_W-1:0] rx_char;
  logic wr_data;
  logic rd_data;
  logic take;
  logic ready_now;
  logic transmit_holding_empty_now;
  logic fifo_change;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;
  reg_sel_t sel;
  logic rx_lost;

  char_fifo_if rxf ();
  char_fifo_if txf ();

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic is_alias(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ALIAS_BASE;
    return (off < ALIAS_SPAN) && (a[1:0] == 2'h0);
  endfunction : is_alias

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] reg_addr);
    return a == reg_addr;
  endfunction : hit

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = sel_none;
    if (is_alias(a)) begin
      s = sel_data;
    end else if (hit(a, FIFO_CONTROL_ADDR)) begin
      s = sel_fifo;
    end else if (hit(a, LINE_STATUS_ADDR)) begin
      s = sel_line;
    end else if (hit(a, MODE_CONTROL_ADDR)) begin
      s = sel_mode;
    end else if (hit(a, INT_STATUS_ADDR)) begin
      s = sel_istat;
    end else if (hit(a, INT_MASK_ADDR)) begin
      s = sel_imask;
    end
    return s;
  endfunction : decode

  function automatic logic [DATA_W-1:0] line_word(input logic ready, input logic ovr,
                                                  input logic empty);
    logic [DATA_W-1:0] w;
    w = WORD_RESET;
    w[LS_READY_BIT] = ready;
    w[LS_OVERRUN_BIT] = ovr;
    w[LS_TRANSMIT_HOLDING_EMPTY_BIT] = empty;
    return w;
  endfunction : line_word

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // Character queues
  // ----------------------------------------
  char_fifo u_rx_fifo (
    .clk(MCLK),
    .rst_n(rst_n),
    .fif(rxf.store)
  );

  char_fifo u_tx_fifo (
    .clk(MCLK),
    .rst_n(rst_n),
    .fif(txf.store)
  );

  // ----------------------------------------
  // Access strobes
  // ----------------------------------------
  assign rx_ev = q.ir_mode ? IR_RX_VALID : SER_RX_VALID;
  assign rx_char = q.ir_mode ? IR_RX_CHAR : SER_RX_CHAR;
  assign wr_data = WR && is_alias(ADDR);
  assign rd_data = RD && is_alias(ADDR);
  assign take = TX_TAKE && q.stage_v;
  assign fifo_change = WR && hit(ADDR, FIFO_CONTROL_ADDR) &&
                       (WDATA[FIFO_EN_BIT] != q.fifo_en);
  assign ready_now = q.fifo_en ? !rxf.empty : q.rx_hold_v;
  assign transmit_holding_empty_now = q.fifo_en ? txf.empty : !q.tx_hold_v;
  assign sel = decode(ADDR);
  assign rx_lost = rx_ev && (q.fifo_en ? rxf.full : (q.rx_hold_v && !rd_data));

  // ----------------------------------------
  // Queue control
  // ----------------------------------------
  assign rxf.push = q.fifo_en && rx_ev && !rxf.full;
  assign rxf.pop = q.fifo_en && rd_data && !rxf.empty;
  assign rxf.flush = fifo_change;
  assign rxf.wdata = rx_char;
  assign txf.push = q.fifo_en && wr_data && !txf.full;
  assign txf.pop = q.fifo_en && !txf.empty && (!q.stage_v || take);
  assign txf.flush = fifo_change;
  assign txf.wdata = WDATA[CHAR_W-1:0];

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  always_comb begin
    int_set = INT_RESET;
    int_set[INT_RX_BIT] = rx_ev;
    int_set[INT_OVR_BIT] = rx_lost;
    int_set[INT_TRANSMIT_HOLDING_EMPTY_BIT] = transmit_holding_empty_now && !q.transmit_holding_empty_prev;
    int_clr = INT_RESET;
    if (WR && hit(ADDR, INT_STATUS_ADDR)) begin
      int_clr = WDATA[INT_W-1:0];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    // Control registers
    if (WR && hit(ADDR, FIFO_CONTROL_ADDR)) begin
      d.fifo_en = WDATA[FIFO_EN_BIT];
    end
    if (WR && hit(ADDR, MODE_CONTROL_ADDR)) begin
      d.ir_mode = WDATA[IR_MODE_BIT];
    end
    if (WR && hit(ADDR, INT_MASK_ADDR)) begin
      d.int_mask = WDATA[INT_W-1:0];
    end
    // Receive holding byte without queue
    if (!q.fifo_en && rd_data) begin
      d.rx_hold_v = 1'b0;
    end
    if (!q.fifo_en && rx_ev) begin
      d.rx_hold = rx_char;
      d.rx_hold_v = 1'b1;
    end
    // Overrun flag, cleared by reading line status
    if (RD && hit(ADDR, LINE_STATUS_ADDR)) begin
      d.overrun = 1'b0;
    end
    if (rx_lost) begin
      d.overrun = 1'b1;
    end
    // Output stage
    if (take) begin
      d.stage_v = 1'b0;
    end
    if (txf.pop) begin
      d.stage = txf.rdata;
      d.stage_v = 1'b1;
    end
    if (!q.fifo_en && q.tx_hold_v && (!q.stage_v || take)) begin
      d.stage = q.tx_hold;
      d.stage_v = 1'b1;
      d.tx_hold_v = 1'b0;
    end
    // Transmit holding byte without queue
    if (!q.fifo_en && wr_data) begin
      d.tx_hold = WDATA[CHAR_W-1:0];
      d.tx_hold_v = 1'b1;
    end
    if (fifo_change) begin
      d.rx_hold_v = 1'b0;
      d.tx_hold_v = 1'b0;
    end
    // Line side outputs follow the mode
    d.ser_v = d.stage_v && !d.ir_mode;
    d.ir_v = d.stage_v && d.ir_mode;
    // Status outputs
    d.ready_o = ready_now;
    d.transmit_holding_empty_o = transmit_holding_empty_now;
    d.transmit_holding_empty_prev = transmit_holding_empty_now;
    // Sticky interrupt bits, set beats clear
    d.int_stat = (q.int_stat & ~int_clr) | int_set;
    d.irq = |(d.int_stat & d.int_mask);
    // Read data stands only in the cycle after the strobe
    d.rdata = WORD_RESET;
    if (RD) begin
      unique case (sel)
        sel_data: begin
          d.rdata[CHAR_W-1:0] = q.fifo_en ? rxf.rdata : q.rx_hold;
        end
        sel_line: begin
          d.rdata = line_word(ready_now, q.overrun, transmit_holding_empty_now);
        end
        sel_fifo: begin
          d.rdata[FIFO_EN_BIT] = q.fifo_en;
        end
        sel_mode: begin
          d.rdata[IR_MODE_BIT] = q.ir_mode;
        end
        sel_istat: begin
          d.rdata[INT_W-1:0] = q.int_stat;
        end
        sel_imask: begin
          d.rdata[INT_W-1:0] = q.int_mask;
        end
        sel_none: begin
          d.rdata = WORD_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.transmit_holding_empty_o <= 1'b1;
      q.transmit_holding_empty_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RDATA = q.rdata;
  assign SER_TX_VALID = q.ser_v;
  assign IR_TX_VALID = q.ir_v;
  assign TX_CHAR = q.stage;
  assign DATA_READY = q.ready_o;
  assign TX_HOLD_EMPTY = q.transmit_holding_empty_o;
  assign FIFO_ENABLE = q.fifo_en;
  assign IRQ = q.irq;
endmodule : shadow_data_port

// >>> hdl/shadow_pkg.sv
// How it works
// - Sixteen word-spaced aliases reach one data path
// - Read gives selected input byte while ready
// - No FIFO: new byte overwrites, flags overrun
// - FIFO on: read returns and pops head
// - Full receive FIFO drops newcomer, flags overrun
// - No FIFO: write clears empty, loads output
// - No FIFO: extra writes overwrite pending byte
// - FIFO on: sixteen characters accepted until full
// - Write into full transmit FIFO is dropped
package shadow_pkg;
  // ----------------------------------------
  // Bus and data widths
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ALIAS_BASE = 32'h5000_1130;
  localparam logic [31:0] ALIAS_SPAN = 32'h0000_0040;
  localparam logic [31:0] ALIAS_THREE_ADDR = 32'h5000_113C;
  localparam logic [31:0] ALIAS_FOUR_ADDR = 32'h5000_1140;
  localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h5000_1108;
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1114;
  localparam logic [31:0] MODE_CONTROL_ADDR = 32'h5000_1180;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_1184;
  localparam logic [31:0] INT_MASK_ADDR = 32'h5000_1188;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FIFO_EN_BIT = 0;
  localparam int IR_MODE_BIT = 0;
  localparam int LS_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_TRANSMIT_HOLDING_EMPTY_BIT = 5;
  localparam int INT_W = 3;
  localparam int INT_RX_BIT = 0;
  localparam int INT_OVR_BIT = 1;
  localparam int INT_TRANSMIT_HOLDING_EMPTY_BIT = 2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [CHAR_W-1:0] CHAR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;
endpackage : shadow_pkg

// >>> verification/serial_peer.sv
`timescale 1ns/10ps
module serial_peer
  import shadow_pkg::*;
(
  // Control
  input wire logic clk,
  input wire logic stall,
  // Device transmit
  input wire logic ser_tx_valid,
  input wire logic ir_tx_valid,
  input wire logic [CHAR_W-1:0] tx_char,
  output logic tx_take,
  // Device receive
  output logic ser_rx_valid,
  output logic [CHAR_W-1:0] ser_rx_char,
  output logic ir_rx_valid,
  output logic [CHAR_W-1:0] ir_rx_char
);
  logic [8:0] got[$];
  initial begin
    tx_take = 1'h0;
    ser_rx_valid = 1'h0;
    ir_rx_valid = 1'h0;
    ser_rx_char = 8'hA5;
    ir_rx_char = 8'h5A;
  end
  task automatic send(input logic [7:0] c, input logic ir);
    @(posedge clk);
    ser_rx_valid <= !ir;
    ir_rx_valid <= ir;
    ser_rx_char <= c;
    ir_rx_char <= c;
    @(posedge clk);
    ser_rx_valid <= 1'h0;
    ir_rx_valid <= 1'h0;
    ser_rx_char <= ~c;
    ir_rx_char <= ~c;
  endtask : send
  always begin
    @(posedge clk);
    if ((ser_tx_valid || ir_tx_valid) && !stall) begin
      got.push_back({ir_tx_valid, tx_char});
      tx_take <= 1'h1;
      @(posedge clk);
      tx_take <= 1'h0;
      @(posedge clk);
    end
  end
endmodule : serial_peer

// >>> verification/shadow_sva.sv
`timescale 1ns/10ps
module shadow_sva
  import shadow_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  // Line side
  input wire logic SER_RX_VALID,
  input wire logic IR_RX_VALID,
  input wire logic SER_TX_VALID,
  input wire logic IR_TX_VALID,
  input wire logic [CHAR_W-1:0] TX_CHAR,
  input wire logic TX_TAKE,
  // Status
  input wire logic DATA_READY,
  input wire logic TX_HOLD_EMPTY,
  input wire logic FIFO_ENABLE
);
  logic hit;
  logic rxv;
  logic txv;
  assign hit = ADDR >= ALIAS_BASE && ADDR < ALIAS_BASE + ALIAS_SPAN && ADDR[1:0] == 2'h0;
  assign rxv = SER_RX_VALID || IR_RX_VALID;
  assign txv = SER_TX_VALID || IR_TX_VALID;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_wr;
    WR && hit;
  endsequence
  sequence s_rd;
    RD && hit && !FIFO_ENABLE && !rxv ##1 !rxv;
  endsequence
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (RD && ADDR == 32'h5000_1200 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_ready_cause: assert property ($rose(DATA_READY) |-> $past(rxv, 2))
    else $error("data ready without a char");
  a_one_line: assert property (!(SER_TX_VALID && IR_TX_VALID))
    else $error("both outputs offered");
  a_tx_hold: assert property (txv && !TX_TAKE && !$past(TX_TAKE) |=> txv && $stable(TX_CHAR))
    else $error("offered char dropped");
  a_tx_start: assert property (s_wr ##0 (!txv && TX_HOLD_EMPTY) |-> ##[1:4] txv)
    else $error("written char not offered");
  a_empty_drop: assert property (s_wr ##0 !FIFO_ENABLE |-> ##[1:3] !TX_HOLD_EMPTY)
    else $error("holding empty not cleared");
  a_read_clears: assert property (s_rd |-> ##[0:2] !DATA_READY)
    else $error("read left data ready");
endmodule : shadow_sva
bind shadow_data_port shadow_sva shadow_sva_i (.*);

// >>> verification/uart_shadow_rx_tx_buffer_tb.sv
`timescale 1ns/10ps
module uart_shadow_rx_tx_buffer_tb;
  import shadow_pkg::*;
  logic MCLK = 1'h0;
  logic RST_N = 1'h0;
  logic [ADDR_W-1:0] ADDR = 32'h0;
  logic [DATA_W-1:0] WDATA = 32'h0;
  logic WR = 1'h0;
  logic RD = 1'h0;
  logic stall = 1'h0;
  logic [DATA_W-1:0] RDATA, q;
  logic SER_RX_VALID, IR_RX_VALID, SER_TX_VALID, IR_TX_VALID, TX_TAKE;
  logic [CHAR_W-1:0] SER_RX_CHAR, IR_RX_CHAR, TX_CHAR;
  logic DATA_READY, TX_HOLD_EMPTY, FIFO_ENABLE, IRQ;
  int err_count = 0;
  int comparisons = 0;
  always #10 MCLK = ~MCLK;
  shadow_data_port shadow_data_port_i (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SER_RX_VALID(SER_RX_VALID), .SER_RX_CHAR(SER_RX_CHAR),
    .IR_RX_VALID(IR_RX_VALID), .IR_RX_CHAR(IR_RX_CHAR), .SER_TX_VALID(SER_TX_VALID),
    .IR_TX_VALID(IR_TX_VALID), .TX_CHAR(TX_CHAR), .TX_TAKE(TX_TAKE), .DATA_READY(DATA_READY),
    .TX_HOLD_EMPTY(TX_HOLD_EMPTY), .FIFO_ENABLE(FIFO_ENABLE), .IRQ(IRQ));
  serial_peer serial_peer_i (.clk(MCLK), .stall(stall), .ser_tx_valid(SER_TX_VALID),
    .ir_tx_valid(IR_TX_VALID), .tx_char(TX_CHAR), .tx_take(TX_TAKE),
    .ser_rx_valid(SER_RX_VALID), .ser_rx_char(SER_RX_CHAR), .ir_rx_valid(IR_RX_VALID),
    .ir_rx_char(IR_RX_CHAR));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge MCLK);
    WR <= 1'h0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge MCLK);
    RD <= 1'h0;
    #1 q = RDATA;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge MCLK);
    #1;
  endtask : settle
  task automatic drain(input int n);
    for (int i = 0; i < 300 && serial_peer_i.got.size() < n; i++) @(posedge MCLK);
    repeat (20) @(posedge MCLK);
    chk("sent count", serial_peer_i.got.size(), n);
  endtask : drain
  task automatic t_reset();
    chk("hold empty", TX_HOLD_EMPTY, 1'h1);
    rd(ALIAS_THREE_ADDR);
    chk("alias three", q, 32'h0);
    rd(ALIAS_FOUR_ADDR);
    chk("alias four", q, 32'h0);
    rd(32'h5000_1200);
    chk("unmapped", q, 32'h0);
  endtask : t_reset
  task automatic t_rx();
    serial_peer_i.send(8'hA1, 1'h0);
    settle();
    chk("ready", DATA_READY, 1'h1);
    rd(ALIAS_THREE_ADDR);
    chk("rx byte", q, 32'hA1);
    serial_peer_i.send(8'hB2, 1'h0);
    serial_peer_i.send(8'hC3, 1'h0);
    settle();
    rd(ALIAS_FOUR_ADDR);
    chk("overwrite", q, 32'hC3);
    rd(LINE_STATUS_ADDR);
    chk("overrun", q[LS_OVERRUN_BIT], 1'h1);
  endtask : t_rx
  task automatic t_tx();
    serial_peer_i.got.delete();
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 50 && TX_HOLD_EMPTY !== 1'h1; k++) @(posedge MCLK);
      wr(ALIAS_BASE + 32'(4 * i), 32'h80 + i);
      drain(i + 1);
      chk("alias tx", serial_peer_i.got[i], 32'h80 + i);
    end
    serial_peer_i.got.delete();
    stall <= 1'h1;
    wr(ALIAS_BASE, 32'h11);
    repeat (5) @(posedge MCLK);
    wr(ALIAS_BASE, 32'h22);
    wr(ALIAS_BASE, 32'h33);
    #1 chk("hold busy", TX_HOLD_EMPTY, 1'h0);
    stall <= 1'h0;
    drain(2);
    chk("first", serial_peer_i.got[0], 32'h11);
    chk("last", serial_peer_i.got[1], 32'h33);
  endtask : t_tx
  task automatic t_fifo();
    wr(FIFO_CONTROL_ADDR, 32'h1);
    settle();
    chk("fifo on", FIFO_ENABLE, 1'h1);
    for (int i = 0; i < 17; i++) serial_peer_i.send(8'(8'h40 + i), 1'h0);
    settle();
    rd(LINE_STATUS_ADDR);
    chk("full drop", q[LS_OVERRUN_BIT], 1'h1);
    for (int i = 0; i < 16; i++) begin
      rd(ALIAS_BASE + 32'(4 * (15 - i)));
      chk("fifo head", q, 32'h40 + i);
    end
    settle();
    chk("rx empty", DATA_READY, 1'h0);
    serial_peer_i.got.delete();
    stall <= 1'h1;
    wr(ALIAS_BASE, 32'h60);
    repeat (5) @(posedge MCLK);
    for (int i = 1; i < 20; i++) wr(ALIAS_BASE + 32'(4 * (i % 16)), 32'h60 + i);
    stall <= 1'h0;
    drain(17);
    for (int i = 0; i < 17; i++) chk("fifo order", serial_peer_i.got[i], 32'h60 + i);
    wr(FIFO_CONTROL_ADDR, 32'h0);
  endtask : t_fifo
  task automatic t_ir();
    wr(MODE_CONTROL_ADDR, 32'h1);
    serial_peer_i.got.delete();
    serial_peer_i.send(8'h3C, 1'h1);
    serial_peer_i.send(8'h99, 1'h0);
    settle();
    rd(ALIAS_BASE);
    chk("ir byte", q, 32'h3C);
    wr(ALIAS_BASE, 32'hC3);
    drain(1);
    chk("ir out", serial_peer_i.got[0], 32'h1C3);
    wr(MODE_CONTROL_ADDR, 32'h0);
  endtask : t_ir
  task automatic t_irq();
    wr(INT_STATUS_ADDR, 32'h7);
    wr(INT_MASK_ADDR, 32'h1);
    serial_peer_i.send(8'h55, 1'h0);
    settle();
    chk("irq on", IRQ, 1'h1);
    wr(INT_MASK_ADDR, 32'h0);
    settle();
    chk("irq masked", IRQ, 1'h0);
    wr(INT_MASK_ADDR, 32'h1);
    settle();
    chk("irq back", IRQ, 1'h1);
    wr(INT_STATUS_ADDR, 32'h1);
    settle();
    chk("irq clear", IRQ, 1'h0);
    wr(INT_MASK_ADDR, 32'h2);
    serial_peer_i.send(8'h66, 1'h0);
    settle();
    chk("irq overrun", IRQ, 1'h1);
    rd(ALIAS_BASE);
  endtask : t_irq
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'h1;
    settle();
    t_reset();
    t_rx();
    t_tx();
    t_fifo();
    t_ir();
    t_irq();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    err_count++;
    wrap_up();
  end
endmodule : uart_shadow_rx_tx_buffer_tb
